// [hw/comparator_channel.v]
// One comparator channel: input select, polarity, sync and edge events
// Assumes the analog compare result arrives as a digital level per input
module comparator_channel (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Configuration
  input  wire [7:0] ctrl,
  // Digital compare results for each input pairing
  input  wire [7:0] gt_matrix,      // {pref,nsel} -> VIN+ > VIN-
  // Results
  output reg        result,
  output wire       pin_out,
  output wire       pin_oe,
  output wire       event_pulse
);
`include "comparator_ctrl_regs.vh"

  wire [2:0] pair_idx;
  wire       raw_out;
  wire       adj_out;
  wire [1:0] edge_sel;
  reg        sync1_reg;
  reg        prev_reg;
  reg        arm_reg;
  reg  [1:0] edge_prev_reg;

  // Pick the pairing: positive source is the top index bit
  assign pair_idx = {ctrl[`CTL_PREF], ctrl[`CTL_NSEL_HI:`CTL_NSEL_LO]};
  // Raw high when VIN+ exceeds VIN-; off comparators give raw low, which inversion turns high
  assign raw_out  = ctrl[`CTL_ON] & gt_matrix[pair_idx];
  assign adj_out  = raw_out ^ ctrl[`CTL_INV];
  assign edge_sel = ctrl[`CTL_EDGE_HI:`CTL_EDGE_LO];

  // Two-stage synchroniser; result is the second stage
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      result    <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= adj_out;
      result    <= sync1_reg;
      prev_reg  <= result;
    end
  end

  // Arm the any-change flag once each time that mode is newly chosen
  always @(posedge aclk) begin
    if (!aresetn) begin
      edge_prev_reg <= `EDGE_NONE;
      arm_reg       <= 1'b0;
    end else begin
      edge_prev_reg <= edge_sel;
      arm_reg       <= (edge_sel == `EDGE_ANY) &&
                       (edge_prev_reg != `EDGE_ANY);
    end
  end

  // Output drives the remapped pin only when routed
  assign pin_oe  = ctrl[`CTL_OE];
  assign pin_out = ctrl[`CTL_OE] & result;

  // Edge qualification from the synchronised result
  assign event_pulse = arm_reg |
    ((edge_sel == `EDGE_RISE) &  result & ~prev_reg) |
    ((edge_sel == `EDGE_FALL) & ~result &  prev_reg) |
    ((edge_sel == `EDGE_ANY)  & (result ^ prev_reg));

endmodule // comparator_channel

// [hw/comparator_ctrl.v]
// Three-comparator control and status block behind an AXI4-Lite slave
// Assumes analog compare results arrive as digital levels, synchronous-safe
// only after the two-flop chain inside each channel
//
// Local design decision: the AXI4-Lite slave port.
module comparator_ctrl #(
  parameter NUM_CMP = 3
) (
  // Clock and reset
  input  wire                 aclk,
  input  wire                 aresetn,
  // AXI4-Lite write address
  input  wire [15:0]          s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]           s_axi_bresp,
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  // AXI4-Lite read address
  input  wire [15:0]          s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  // Analog front end: per comparator, 8 compare results by pairing
  input  wire [8*NUM_CMP-1:0] gt_matrix,
  // Comparator control levels to the analog front end
  output wire [NUM_CMP-1:0]   comparator_on,
  output wire [NUM_CMP-1:0]   positive_input_ref_select,
  output wire [2*NUM_CMP-1:0] negative_input_select,
  // Remappable output pins
  output wire [NUM_CMP-1:0]   comparator_output_pin_o,
  output wire [NUM_CMP-1:0]   comparator_output_pin_oe,
  // Interrupt
  output wire                 irq
);
`include "comparator_ctrl_regs.vh"

  reg  [7:0]         ctrl_reg [0:NUM_CMP-1];
  reg  [NUM_CMP-1:0] flag_reg;
  reg  [NUM_CMP-1:0] flag_next;
  reg  [NUM_CMP-1:0] en_reg;
  wire [NUM_CMP-1:0] result;
  wire [NUM_CMP-1:0] event_pulse;

  // Write channel holding registers
  reg                aw_full_reg;
  reg  [`IDX_W-1:0]  aw_idx_reg;
  reg                w_full_reg;
  reg  [31:0]        w_data_reg;
  reg  [3:0]         w_strb_reg;
  wire               wr_go;
  reg                wr_hit;
  reg  [NUM_CMP-1:0] ctl_we;
  reg                clr_we;
  reg                en_we;
  reg                set_we;

  // Read path
  wire               rd_go;
  wire [`IDX_W-1:0]  ar_idx;
  reg  [31:0]        rd_data;
  reg                rd_hit;

  // Byte address is four times the printed index
  assign ar_idx = s_axi_araddr[`IDX_W+1:2];

  // Accept address and data independently, one write in flight
  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign wr_go         = aw_full_reg && w_full_reg && !s_axi_bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      aw_idx_reg   <= {`IDX_W{1'b0}};
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[`IDX_W+1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write decode; status register ignores writes
  always @* begin
    ctl_we = {NUM_CMP{1'b0}};
    clr_we = 1'b0;
    en_we  = 1'b0;
    set_we = 1'b0;
    wr_hit = 1'b1;
    if (aw_idx_reg == `CMP1_CTRL_IDX) begin
      ctl_we[0] = 1'b1;
    end else if (aw_idx_reg == `CMP2_CTRL_IDX) begin
      ctl_we[1] = 1'b1;
    end else if (aw_idx_reg == `CMP3_CTRL_IDX) begin
      ctl_we[2] = 1'b1;
    end else if (aw_idx_reg == `CMP_RESULT_IDX) begin
      wr_hit = 1'b1;
    end else if (aw_idx_reg == `CMP_EVT_STAT_IDX) begin
      wr_hit = 1'b1;
    end else if (aw_idx_reg == `CMP_EVT_CLR_IDX) begin
      clr_we = 1'b1;
    end else if (aw_idx_reg == `CMP_EVT_EN_IDX) begin
      en_we = 1'b1;
    end else if (aw_idx_reg == `CMP_EVT_SET_IDX) begin
      set_we = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Per-comparator control register and channel logic
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g = g + 1) begin : gen_cmp
      // Reset value turns the comparator off
      always @(posedge aclk) begin
        if (!aresetn) begin
          ctrl_reg[g] <= `CTL_RESET;
        end else if (wr_go && ctl_we[g] && w_strb_reg[0]) begin
          ctrl_reg[g] <= w_data_reg[7:0];
        end
      end

      comparator_channel u_channel (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .ctrl           (ctrl_reg[g]),
        .gt_matrix      (gt_matrix[8*g+7:8*g]),
        .result         (result[g]),
        .pin_out        (comparator_output_pin_o[g]),
        .pin_oe         (comparator_output_pin_oe[g]),
        .event_pulse    (event_pulse[g])
      );

      // Drive analog front end selection and power
      assign comparator_on[g]             = ctrl_reg[g][`CTL_ON];
      assign positive_input_ref_select[g] = ctrl_reg[g][`CTL_PREF];
      assign negative_input_select[2*g+1:2*g] =
        ctrl_reg[g][`CTL_NSEL_HI:`CTL_NSEL_LO];
    end
  endgenerate

  // Sticky event flags: events and software set win over a clear
  always @* begin
    flag_next = flag_reg;
    if (wr_go && clr_we && w_strb_reg[0]) begin
      flag_next = flag_next & ~w_data_reg[NUM_CMP-1:0];
    end
    if (wr_go && set_we && w_strb_reg[0]) begin
      flag_next = flag_next | w_data_reg[NUM_CMP-1:0];
    end
    flag_next = flag_next | event_pulse;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= {NUM_CMP{1'b0}};
      en_reg   <= {NUM_CMP{1'b0}};
    end else begin
      flag_reg <= flag_next;
      if (wr_go && en_we && w_strb_reg[0]) begin
        en_reg <= w_data_reg[NUM_CMP-1:0];
      end
    end
  end

  // Level interrupt; enables gate only the output, never the flags
  assign irq = |(flag_reg & en_reg);

  // Read decode
  always @* begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (ar_idx == `CMP1_CTRL_IDX) begin
      rd_data[7:0] = ctrl_reg[0];
    end else if (ar_idx == `CMP2_CTRL_IDX) begin
      rd_data[7:0] = ctrl_reg[1];
    end else if (ar_idx == `CMP3_CTRL_IDX) begin
      rd_data[7:0] = ctrl_reg[2];
    end else if (ar_idx == `CMP_RESULT_IDX) begin
      // Upper bits stay zero comparator 3 in bit 2
      rd_data[NUM_CMP-1:0] = result;
    end else if (ar_idx == `CMP_EVT_STAT_IDX) begin
      rd_data[NUM_CMP-1:0] = flag_reg;
    end else if (ar_idx == `CMP_EVT_EN_IDX) begin
      rd_data[NUM_CMP-1:0] = en_reg;
    end else if (ar_idx == `CMP_EVT_CLR_IDX) begin
      rd_hit = 1'b1; // Write-only, reads zero
    end else if (ar_idx == `CMP_EVT_SET_IDX) begin
      rd_hit = 1'b1; // Write-only, reads zero
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One read in flight; data registered with the response
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // comparator_ctrl

// [hw/comparator_ctrl_regs.vh]
// Register offsets, field positions and reset values of the comparator block
// Assumes an AXI4-Lite slave with 32-bit data, one register per aligned word
`ifndef COMPARATOR_CTRL_REGS_VH
`define COMPARATOR_CTRL_REGS_VH

// Printed offsets are not all multiples of four: they are register indices
`define CMP3_CTRL_IDX    12'hF25
`define CMP_RESULT_IDX   12'hF70
`define CMP2_CTRL_IDX    12'hFD1
`define CMP1_CTRL_IDX    12'hFD2
`define CMP_EVT_STAT_IDX 12'hF71
`define CMP_EVT_CLR_IDX  12'hF72
`define CMP_EVT_EN_IDX   12'hF73
`define CMP_EVT_SET_IDX  12'hF74
`define IDX_W            12

// Control register fields
`define CTL_ON      7
`define CTL_OE      6
`define CTL_INV     5
`define CTL_EDGE_HI 4
`define CTL_EDGE_LO 3
`define CTL_PREF    2
`define CTL_NSEL_HI 1
`define CTL_NSEL_LO 0
`define CTL_RESET   8'h1F

// Edge select encodings
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_ANY  2'h3

// AXI responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// [tb/analog_front_model.sv]
// Analog front end: pin and reference voltages for three comparators
// Assumes the bench sets the voltages as plain integers
module analog_front_model (
  // Compare results by pairing
  output logic [23:0] gt_matrix
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pin A, pins B C D, fixed reference, ladder; all pins analog inputs
  int v [3][6];
  // Ties on equal voltages read low, as an offset would allow
  always_comb begin
    for (int c = 0; c < 3; c++)
      for (int k = 0; k < 8; k++)
        gt_matrix[8*c+k] = (k[2] ? v[c][5] : v[c][0])
          > v[c][1+k[1:0]];
  end
endmodule // analog_front_model

// [tb/comparator_ctrl_assertions.sv]
// Checker for the comparator block: bus handshakes and pin outputs
// Assumes one clock domain and binding to comparator_ctrl
module comparator_checker #(
  parameter NUM_CMP = 3
) (
  // Clock and reset
  input logic                 aclk,
  input logic                 aresetn,
  // Bus handshakes
  input logic                 s_axi_awvalid,
  input logic                 s_axi_awready,
  input logic                 s_axi_bvalid,
  input logic                 s_axi_bready,
  input logic                 s_axi_arvalid,
  input logic                 s_axi_arready,
  input logic                 s_axi_rvalid,
  input logic                 s_axi_rready,
  // Comparator outputs
  input logic [NUM_CMP-1:0]   comparator_on,
  input logic [NUM_CMP-1:0]   positive_input_ref_select,
  input logic [2*NUM_CMP-1:0] negative_input_select,
  input logic [NUM_CMP-1:0]   comparator_output_pin_o,
  input logic [NUM_CMP-1:0]   comparator_output_pin_oe,
  input logic                 irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Reset is checked at the first edge after release, where it is enabled
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_ctrl_a: assert property ($rose(aresetn) |-> !comparator_on
    && &positive_input_ref_select && &negative_input_select)
    else $error("control outputs not at reset value");
  reset_out_a: assert property ($rose(aresetn) |-> !irq
    && !comparator_output_pin_oe) else $error("outputs live after reset");
  pin_gate_a: assert property (
    !(comparator_output_pin_o & ~comparator_output_pin_oe))
    else $error("pin driven while routing off");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  read_once_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  read_cause_a: assert property (
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
    else $error("read answered without request");
  write_once_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  write_block_a: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
endmodule // comparator_checker

bind comparator_ctrl comparator_checker #(.NUM_CMP(NUM_CMP)) chk_i (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .comparator_on, .positive_input_ref_select,
  .negative_input_select, .comparator_output_pin_o,
  .comparator_output_pin_oe, .irq);

// [tb/comparator_ctrl_test.sv]
// Self-checking bench for the comparator control block
// Assumes the register header on the include path
`include "comparator_ctrl_regs.vh"
module comparator_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 0, aresetn = 0, irq;
  logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [23:0] gt_matrix;
  logic [2:0]  comparator_on, positive_input_ref_select;
  logic [2:0]  comparator_output_pin_o, comparator_output_pin_oe;
  logic [5:0]  negative_input_select;
  logic [11:0] ctl [3] = '{`CMP1_CTRL_IDX, `CMP2_CTRL_IDX, `CMP3_CTRL_IDX};
  int          fail_count = 0, cmp_count = 0;

  comparator_ctrl #(.NUM_CMP(3)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gt_matrix,
    .comparator_on, .positive_input_ref_select, .negative_input_select,
    .comparator_output_pin_o, .comparator_output_pin_oe, .irq);
  analog_front_model afe (.gt_matrix);

  always #50 aclk = ~aclk;

  task automatic complete_run;
    if (fail_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // A bus wait that ran out ends the run as a failure
  task automatic hang(int n);
    if (n >= 50) begin
      fail_count++;
      complete_run();
    end
  endtask
  // Handshake values are sampled before the edge's own updates land
  task automatic wr(logic [11:0] i, logic [31:0] v);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      n++;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 0;
    r = s_axi_bresp;
    hang(n);
  endtask
  task automatic rc(string s, logic [11:0] i, logic [31:0] e);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      n++;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 0;
    hang(n);
    chk(s, e, s_axi_rdata);
    r = s_axi_rresp;
  endtask

  // Reset values, arming at reset, unmapped read
  task automatic t_reset;
    for (int c = 0; c < 3; c++) rc("ctrl", ctl[c], 32'h1F);
    rc("armed", `CMP_EVT_STAT_IDX, 32'h7);
    wr(`CMP_EVT_CLR_IDX, 32'h7);
    rc("cleared", `CMP_EVT_STAT_IDX, 32'h0);
    rc("unmapped", 12'h000, 32'h0);
    chk("resp", 32'h2, r);
    wr(12'h000, 32'h7);
    chk("wr resp", 32'h2, r);
  endtask
  // Every pairing per comparator, then inversion, enable and pin
  task automatic t_select;
    int t [6];
    for (int c = 0; c < 3; c++)
      for (int k = 0; k < 8; k++) begin
        if (k > 3) begin
          t = '{0, 9, 9, 9, 9, 5};
        end else begin
          t = '{5, 9, 9, 9, 9, 0};
        end
        t[1 + k % 4] = 1;
        afe.v[c] <= t;
        wr(ctl[c], 32'h80 + k);
        chk("sel", k, {positive_input_ref_select[c],
          negative_input_select[2*c+:2]});
        repeat (4) @(posedge aclk);
        rc("pair", `CMP_RESULT_IDX, (2 << c) - 1);
      end
    wr(ctl[0], 32'hA7);
    wr(`CMP_RESULT_IDX, 32'hFF);
    chk("ro resp", 32'h0, r);
    wr(ctl[1], 32'h07);
    wr(ctl[2], 32'hC7);
    repeat (4) @(posedge aclk);
    rc("invert", `CMP_RESULT_IDX, 32'h4);
    chk("on", 32'h5, comparator_on);
    chk("pin", 32'h44, {comparator_output_pin_oe, 1'b0,
      comparator_output_pin_o});
  endtask
  // Edge modes on comparator 1: arming, rise and fall
  task automatic t_edges;
    for (logic [2:0] m = 1; m < 4; m++) begin
      wr(`CMP_EVT_CLR_IDX, 32'h7);
      afe.v[0][4] <= 9;
      // Let the old setting's result settle before the new edge mode
      repeat (4) @(posedge aclk);
      wr(ctl[0], {24'h0, 3'h4, m[1:0], 3'h7});
      repeat (4) @(posedge aclk);
      rc("arm", `CMP_EVT_STAT_IDX, m == 3);
      wr(`CMP_EVT_CLR_IDX, 32'h7);
      afe.v[0][4] <= 1;
      repeat (4) @(posedge aclk);
      rc("rise", `CMP_EVT_STAT_IDX, m[0]);
      wr(`CMP_EVT_CLR_IDX, 32'h7);
      afe.v[0][4] <= 9;
      repeat (4) @(posedge aclk);
      rc("fall", `CMP_EVT_STAT_IDX, m[1]);
    end
  endtask
  // Simulated event, mask, clear, then a reset in mid-run
  task automatic t_irq;
    wr(`CMP_EVT_CLR_IDX, 32'h7);
    wr(`CMP_EVT_EN_IDX, 32'h2);
    wr(`CMP_EVT_SET_IDX, 32'h2);
    repeat (2) @(posedge aclk);
    chk("irq set", 1, irq);
    wr(`CMP_EVT_EN_IDX, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq mask", 0, irq);
    rc("kept", `CMP_EVT_STAT_IDX, 32'h2);
    wr(`CMP_EVT_EN_IDX, 32'h2);
    wr(`CMP_EVT_CLR_IDX, 32'h2);
    repeat (2) @(posedge aclk);
    chk("irq clr", 0, irq);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rc("rst", ctl[0], 32'h1F);
  endtask

  // Reset, then each scenario in turn
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_select;
    t_edges;
    t_irq;
    complete_run;
  end
endmodule // comparator_ctrl_test
